//--- rtl/pin_mux_cell.sv
// combinational per-pin routing between port logic, peripherals and pad
`timescale 1ns/10ps
module pin_mux_cell
	import port9_pkg::*;
(
	pin_mux_if.mux m
);
	genvar i;
	generate
		for (i = 0; i < PIN_COUNT; i++) begin : g_pin
			logic src_out;
			logic src_oe;
			assign src_out      = m.mode[i] ? m.alt_out[i] : m.port_out[i];
			assign src_oe       = m.mode[i] ? m.alt_oe[i]  : m.port_oe[i];
			// open drain: only a low is driven, a high releases the pin
			assign m.pad_out[i] = m.od[i] ? 1'b0 : src_out;
			assign m.pad_oe[i]  = m.od[i] ? (src_oe & ~src_out) : src_oe;
			// peripherals see a quiet low unless routed or set in ALWAYS_IN_MASK, so a stray pin level cannot fire them
			assign m.alt_in[i]  = (m.mode[i] | ALWAYS_IN_MASK[i]) & m.pad_in[i];
			assign m.port_in[i] = m.pad_in[i];
		end
	endgenerate
endmodule

//--- rtl/pin_mux_if.sv
// per-pin control and data carried between the register block and the mux
`timescale 1ns/10ps
interface pin_mux_if;
	logic [8:0] mode;
	logic [8:0] od;
	logic [8:0] port_out;
	logic [8:0] port_oe;
	logic [8:0] alt_out;
	logic [8:0] alt_oe;
	logic [8:0] pad_in;
	logic [8:0] pad_out;
	logic [8:0] pad_oe;
	logic [8:0] alt_in;
	logic [8:0] port_in;

	modport ctrl (
		output mode, od, port_out, port_oe, alt_out, alt_oe, pad_in,
		input  pad_out, pad_oe, alt_in, port_in
	);
	modport mux (
		input  mode, od, port_out, port_oe, alt_out, alt_oe, pad_in,
		output pad_out, pad_oe, alt_in, port_in
	);
endinterface

//--- rtl/port9_pin_function_select.sv
// port 9 pin-function select: mode and open-drain registers plus pad routing
//
// What this block does
// - mode bit 0 keeps pin as port; 1 routes its alternate peripheral function.
// - mode register is a 16-bit word; unimplemented bits read zero.
// - byte/bit access to mode bits 8-15 goes through the high-byte register.
// - low and high mode bytes accessible separately by byte and bit accesses.
// - output-type bit on pins 8 and 9: 0 push-pull, 1 open drain.
`timescale 1ns/10ps
module port9_pin_function_select
	import port9_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk,
	input  wire logic       sys_rst,
	// cpu register access
	input  wire logic [11:0] reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire acc_size_t   reg_size,
	input  wire logic [2:0]  reg_bit,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	output logic             reg_rvalid,
	// general port logic, pin index order 0,1,6,7,8,9,13,14,15
	input  wire logic [8:0]  port_out,
	input  wire logic [8:0]  port_oe,
	output logic      [8:0]  port_in,
	// peripheral side: async_tx, async_rx, timer_out, serial_in, serial_out,
	// serial_clock_io, ext_irq_in_a, ext_irq_in_b, ext_irq_in_c
	input  wire logic [8:0]  alt_out,
	input  wire logic [8:0]  alt_oe,
	output logic      [8:0]  alt_in,
	// pads
	input  wire logic [8:0]  pad_in,
	output logic      [8:0]  pad_out,
	output logic      [8:0]  pad_oe
);
	logic [15:0] pin_function_mode_reg_q;
	logic [15:0] pin_function_mode_reg_d;
	logic [7:0]  open_drain_select_reg_q;
	logic [7:0]  open_drain_select_reg_d;
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;
	logic        rvalid_q;
	logic        rvalid_d;
	logic [15:0] wmask;
	logic [15:0] wval;
	logic [15:0] hmask;
	logic [15:0] hval;
	logic [15:0] mode_low_new;
	logic [15:0] mode_high_new;
	logic [7:0]  od_new;
	logic        is_word;
	logic        hit_word;
	logic        hit_low;
	logic        hit_high;
	logic        hit_od;

	logic [8:0]  sync_a_q;
	logic [8:0]  sync_b_q;
	logic [8:0]  pad_out_q;
	logic [8:0]  pad_oe_q;
	logic [8:0]  alt_in_q;
	logic [8:0]  port_in_q;
	logic [8:0]  sync_a_d;
	logic [8:0]  sync_b_d;
	logic [8:0]  pad_out_d;
	logic [8:0]  pad_oe_d;
	logic [8:0]  alt_in_d;
	logic [8:0]  port_in_d;

	pin_mux_if mux_bus ();

	// register writes and reads
	always_comb begin
		pin_function_mode_reg_d = pin_function_mode_reg_q;
		open_drain_select_reg_d = open_drain_select_reg_q;
		rdata_d  = 16'h0000;
		rvalid_d = reg_rd;
		wmask    = 16'h0000;
		wval     = 16'h0000;
		// the high byte and the open-drain register refuse whole-word accesses
		is_word  = (reg_size == ACC_WORD);
		hit_word = (reg_addr == PMC_WORD_ADDR) && is_word;
		hit_low  = (reg_addr == PMC_LOW_ADDR);
		hit_high = (reg_addr == PMC_HIGH_ADDR) && !is_word;
		hit_od   = (reg_addr == OD_ADDR) && !is_word;
		unique case (reg_size)
			ACC_WORD: begin
				wmask = 16'hFFFF;
				wval  = reg_wdata;
			end
			ACC_BYTE: begin
				wmask = 16'h00FF;
				wval  = {8'h00, reg_wdata[7:0]};
			end
			ACC_BIT: begin
				wmask = 16'h0001 << reg_bit;
				wval  = {16{reg_wdata[0]}};
			end
			default: begin
				wmask = 16'h0000;
				wval  = 16'h0000;
			end
		endcase
		// high-byte accesses reuse the low-byte byte and bit masks moved up by eight bits
		hmask = wmask << 8;
		hval  = wval << 8;
		// merges are formed for every access; only an address hit commits one
		mode_low_new  = (pin_function_mode_reg_q & ~wmask) | (wval & wmask);
		mode_high_new = (pin_function_mode_reg_q & ~hmask) | (hval & hmask);
		od_new        = (open_drain_select_reg_q & ~wmask[7:0]) | (wval[7:0] & wmask[7:0]);
		if (reg_wr) begin
			if (hit_low) begin
				pin_function_mode_reg_d = mode_low_new & PMC_IMPL_MASK;
			end else if (hit_high) begin
				pin_function_mode_reg_d = mode_high_new & PMC_IMPL_MASK;
			end else if (hit_od) begin
				open_drain_select_reg_d = od_new & OD_IMPL_MASK;
			end
		end
		if (reg_rd) begin
			if (hit_word) begin
				rdata_d = pin_function_mode_reg_q;
			end else if (hit_low) begin
				rdata_d = {8'h00, pin_function_mode_reg_q[7:0]};
			end else if (hit_high) begin
				rdata_d = {8'h00, pin_function_mode_reg_q[15:8]};
			end else if (hit_od) begin
				rdata_d = {8'h00, open_drain_select_reg_q};
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pin_function_mode_reg_q <= PMC_RESET;
			open_drain_select_reg_q <= OD_RESET;
			rdata_q                 <= 16'h0000;
			rvalid_q                <= 1'b0;
		end else begin
			pin_function_mode_reg_q <= pin_function_mode_reg_d;
			open_drain_select_reg_q <= open_drain_select_reg_d;
			rdata_q                 <= rdata_d;
			rvalid_q                <= rvalid_d;
		end
	end

	// spread register bits onto the pin index order
	genvar p;
	generate
		for (p = 0; p < PIN_COUNT; p++) begin : g_mode
			assign mux_bus.mode[p] = pin_function_mode_reg_q[PIN_REG_BIT[p]];
			if (p == OD_PIN_LO) begin : g_od_lo
				assign mux_bus.od[p] = open_drain_select_reg_q[0];
			end else if (p == OD_PIN_HI) begin : g_od_hi
				assign mux_bus.od[p] = open_drain_select_reg_q[1];
			end else begin : g_od_none
				assign mux_bus.od[p] = 1'b0;
			end
		end
	endgenerate

	assign mux_bus.port_out = port_out;
	assign mux_bus.port_oe  = port_oe;
	assign mux_bus.alt_out  = alt_out;
	assign mux_bus.alt_oe   = alt_oe;
	// only the second sync stage feeds logic
	assign mux_bus.pad_in   = sync_b_q;

	pin_mux_cell u_mux (
		.m (mux_bus.mux)
	);

	// two-stage pad synchroniser; nothing but the second stage reads the first
	always_comb begin
		sync_a_d = pad_in;
		sync_b_d = sync_a_q;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync_a_q <= 9'h000;
			sync_b_q <= 9'h000;
		end else begin
			sync_a_q <= sync_a_d;
			sync_b_q <= sync_b_d;
		end
	end

	// registered outputs; costs one cycle of latency on every path
	always_comb begin
		pad_out_d = mux_bus.pad_out;
		pad_oe_d  = mux_bus.pad_oe;
		alt_in_d  = mux_bus.alt_in;
		port_in_d = mux_bus.port_in;
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			pad_out_q <= 9'h000;
			pad_oe_q  <= 9'h000;
			alt_in_q  <= 9'h000;
			port_in_q <= 9'h000;
		end else begin
			pad_out_q <= pad_out_d;
			pad_oe_q  <= pad_oe_d;
			alt_in_q  <= alt_in_d;
			port_in_q <= port_in_d;
		end
	end

	assign reg_rdata  = rdata_q;
	assign reg_rvalid = rvalid_q;
	assign pad_out    = pad_out_q;
	assign pad_oe     = pad_oe_q;
	assign alt_in     = alt_in_q;
	assign port_in    = port_in_q;
endmodule

//--- rtl/port9_pkg.sv
// constants, register map and access types for the port 9 pin-function select
package port9_pkg;
	localparam int          PIN_COUNT      = 9;
	// register byte addresses (low 12 bits of the cpu address)
	localparam logic [11:0] PMC_WORD_ADDR  = 12'h0452;
	localparam logic [11:0] PMC_LOW_ADDR   = 12'h0452;
	localparam logic [11:0] PMC_HIGH_ADDR  = 12'h0453;
	localparam logic [11:0] OD_ADDR        = 12'h047A;
	// implemented bits and reset values
	localparam logic [15:0] PMC_IMPL_MASK  = 16'hE3C3;
	localparam logic [15:0] PMC_RESET      = 16'h0000;
	localparam logic [7:0]  OD_IMPL_MASK   = 8'h03;
	localparam logic [7:0]  OD_RESET       = 8'h00;
	// pin index -> mode register bit: pins 0,1,6,7,8,9,13,14,15
	localparam int          PIN_REG_BIT [PIN_COUNT] = '{0, 1, 6, 7, 8, 9, 13, 14, 15};
	// pins whose peripheral input stays connected in port mode (key return, timer in)
	localparam logic [8:0]  ALWAYS_IN_MASK = 9'h007;
	// pin indices of pins 8 and 9, the only ones with an output-type bit
	localparam int          OD_PIN_LO      = 4;
	localparam int          OD_PIN_HI      = 5;

	typedef enum logic [1:0] {
		ACC_WORD = 2'h0,
		ACC_BYTE = 2'h1,
		ACC_BIT  = 2'h2
	} acc_size_t;
endpackage

//--- tb/port9_asserts.sv
// port-level assertions for the port 9 pin-function select
`timescale 1ns/10ps
module port9_asserts
	import port9_pkg::*;
(
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        sys_rst,
	// register bus and pads
	input wire logic [11:0] reg_addr,
	input wire logic        reg_rd,
	input wire acc_size_t   reg_size,
	input wire logic [15:0] reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic [8:0]  pad_out,
	input wire logic [8:0]  pad_oe,
	input wire logic [8:0]  alt_in
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (sys_rst);
	sequence word_rd;
		reg_rd && reg_addr == PMC_WORD_ADDR && reg_size == ACC_WORD;
	endsequence
	sequence byte_rd(logic [11:0] a);
		reg_rd && reg_addr == a && reg_size != ACC_WORD;
	endsequence
	a_read_answer: assert property (reg_rd |=> reg_rvalid)
		else $error("read not answered");
	a_idle_quiet: assert property (!reg_rd |=> !reg_rvalid && reg_rdata == 16'h0000)
		else $error("stray read data");
	a_word_gaps_zero: assert property (word_rd |=> (reg_rdata & ~PMC_IMPL_MASK) == 0)
		else $error("unimplemented mode bit read set");
	a_low_gaps_zero: assert property (byte_rd(PMC_LOW_ADDR) |=> (reg_rdata & 16'hFF3C) == 0)
		else $error("low byte gap set");
	a_high_gaps_zero: assert property (byte_rd(PMC_HIGH_ADDR) |=> (reg_rdata & 16'hFF1C) == 0)
		else $error("high byte gap set");
	a_od_gaps_zero: assert property (reg_rd && reg_addr == OD_ADDR |=> (reg_rdata & 16'hFFFC) == 0)
		else $error("open-drain gap set");
	a_reset_clears: assert property ($fell(sys_rst) |-> pad_oe == 0 && pad_out == 0 && alt_in == 0)
		else $error("outputs not cleared by reset");
endmodule
bind port9_pin_function_select port9_asserts chk_u (.ref_clk, .sys_rst, .reg_addr, .reg_rd,
	.reg_size, .reg_rdata, .reg_rvalid, .pad_out, .pad_oe, .alt_in);

//--- tb/tb.sv
// self-checking bench for the port 9 pin-function select
`timescale 1ns/10ps
module tb;
	import port9_pkg::*;
	logic        ref_clk, sys_rst, reg_wr, reg_rd, reg_rvalid;
	logic [11:0] reg_addr;
	acc_size_t   reg_size;
	logic [2:0]  reg_bit;
	logic [15:0] reg_wdata, reg_rdata;
	logic [8:0]  port_out, port_oe, port_in, alt_out, alt_oe, alt_in, pad_in, pad_out, pad_oe;
	int          n_mismatch, checks_done, cyc, m_mode, m_od;
	port9_pin_function_select dut_u (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd,
		.reg_size, .reg_bit, .reg_wdata, .reg_rdata, .reg_rvalid, .port_out, .port_oe,
		.port_in, .alt_out, .alt_oe, .alt_in, .pad_in, .pad_out, .pad_oe);
	initial begin
		ref_clk = 0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// one access; the model answers reads with the value held before the access
	task automatic acc(bit wr, logic [11:0] a, acc_size_t s, int b, logic [15:0] d);
		int sh, bm, nv, e;
		sh = (a == PMC_HIGH_ADDR) ? 8 : 0;
		bm = (s == ACC_WORD) ? 16'hFFFF : (s == ACC_BYTE) ? 16'h00FF << sh : 1 << (sh + b);
		nv = (s == ACC_WORD) ? d : (s == ACC_BYTE) ? d[7:0] << sh : {16{d[0]}};
		e = (a == OD_ADDR) ? ((s == ACC_WORD) ? 0 : m_od) : (a[11:1] != PMC_LOW_ADDR[11:1]) ? 0
			: (s == ACC_WORD) ? (sh ? 0 : m_mode) : (m_mode >> sh) & 16'h00FF;
		if (wr && a == OD_ADDR && s != ACC_WORD)
			m_od = (m_od & ~bm) | (nv & bm & OD_IMPL_MASK);
		else if (wr && e != -1 && a[11:1] == PMC_LOW_ADDR[11:1] && !(sh && s == ACC_WORD))
			m_mode = (m_mode & ~bm) | (nv & bm & PMC_IMPL_MASK);
		@(posedge ref_clk);
		{reg_wr, reg_rd, reg_addr, reg_bit, reg_wdata} <= {wr, !wr, a, b[2:0], d};
		reg_size <= s;
		@(posedge ref_clk);
		{reg_wr, reg_rd} <= 2'h0;
		if (!wr) begin
			#1;
			chk("reg_rdata", e[15:0], reg_rdata);
		end
	endtask
	// pads are held four cycles so the synchroniser has settled; keep leaves them as they are
	task automatic pins(bit keep = 0);
		logic [8:0] eo, eoe, m;
		@(posedge ref_clk);
		if (!keep) begin
			{port_out, port_oe, alt_out} <= 27'($urandom);
			{alt_oe, pad_in} <= 18'($urandom);
		end
		repeat (4) @(posedge ref_clk);
		#1;
		for (int i = 0; i < 9; i++) begin
			m[i] = m_mode[PIN_REG_BIT[i]];
			eo[i] = m[i] ? alt_out[i] : port_out[i];
			eoe[i] = m[i] ? alt_oe[i] : port_oe[i];
			if (i inside {OD_PIN_LO, OD_PIN_HI} && m_od[i - OD_PIN_LO]) begin
				eoe[i] = eoe[i] & ~eo[i];
				eo[i] = 1'b0;
			end
		end
		chk("pad_out", 16'(eo), 16'(pad_out));
		chk("pad_oe", 16'(eoe), 16'(pad_oe));
		chk("alt_in", 16'(pad_in & (m | ALWAYS_IN_MASK)), 16'(alt_in));
		chk("port_in", 16'(pad_in), 16'(port_in));
	endtask
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_mismatch++;
			tally_and_finish();
		end
	end
	initial begin
		sys_rst = 1;
		{reg_wr, reg_rd, reg_addr, reg_bit, reg_wdata, port_out, port_oe} = '0;
		{alt_out, alt_oe, pad_in} = '0;
		reg_size = ACC_WORD;
		void'($urandom(32'hfc06_b533));
		repeat (10) @(posedge ref_clk);
		sys_rst <= 0;
		acc(0, PMC_WORD_ADDR, ACC_WORD, 0, 0);
		acc(0, OD_ADDR, ACC_BYTE, 0, 0);
		pins();
		$display("test reset done");
		repeat (12) begin
			acc(1, PMC_WORD_ADDR, ACC_WORD, 0, 16'($urandom));
			acc(1, OD_ADDR, ACC_BIT, $urandom % 2, 16'($urandom));
			pins();
			acc(0, PMC_WORD_ADDR, ACC_WORD, 0, 0);
		end
		$display("test word and pins done");
		for (int i = 0; i < 16; i++) begin
			acc(1, i[3] ? PMC_HIGH_ADDR : PMC_LOW_ADDR, ACC_BIT, i % 8, 16'($urandom));
			acc(0, i[3] ? PMC_HIGH_ADDR : PMC_LOW_ADDR, acc_size_t'(1 + i[0]), 0, 0);
		end
		acc(1, PMC_LOW_ADDR, ACC_BYTE, 0, 16'($urandom));
		acc(1, PMC_HIGH_ADDR, ACC_WORD, 0, 16'hFFFF);
		acc(0, PMC_HIGH_ADDR, ACC_WORD, 0, 0);
		acc(0, 12'h0454, ACC_WORD, 0, 0);
		acc(0, PMC_WORD_ADDR, ACC_WORD, 0, 0);
		pins();
		$display("test byte and bit done");
		// open-drain alternate bring-up in software order; the choice bit lives outside
		@(posedge ref_clk);
		port_out <= port_out | 9'h030;
		acc(1, OD_ADDR, ACC_BYTE, 0, 16'h0003);
		acc(1, PMC_HIGH_ADDR, ACC_BYTE, 0, 16'h0003);
		pins(1);
		acc(0, PMC_HIGH_ADDR, ACC_BIT, 1, 0);
		$display("test open-drain bring-up done");
		// reset in mid-run with busy pins: outputs and registers fall back to zero
		@(posedge ref_clk);
		sys_rst  <= 1;
		port_out <= 9'h1FF;
		port_oe  <= 9'h1FF;
		pad_in   <= 9'h1FF;
		repeat (3) @(posedge ref_clk);
		sys_rst <= 0;
		m_mode = 0;
		m_od   = 0;
		#1;
		chk("pad_out", 16'h0000, 16'(pad_out));
		chk("pad_oe", 16'h0000, 16'(pad_oe));
		acc(0, PMC_WORD_ADDR, ACC_WORD, 0, 0);
		acc(0, OD_ADDR, ACC_BYTE, 0, 0);
		pins();
		$display("test mid-run reset done");
		tally_and_finish();
	end
endmodule
